//--- core/pwmcmp_pkg.sv
/*
	pwmcmp_pkg: register offsets, field layout and reset values of the periodic comparison unit.
	assumes: imported whole by every design file of the block.
*/
package pwmcmp_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 4;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_MODE   = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_VALUE  = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 4'hC;

	// mode register fields
	localparam int FLD_ENABLE   = 0;
	localparam int FLD_TRIG_LSB = 4;
	localparam int FLD_PER_LSB  = 8;
	localparam int FLD_PCNT_LSB = 12;
	localparam int FLD_UPER_LSB = 16;
	localparam int FLD_UCNT_LSB = 20;

	// status / mask bits
	localparam int ST_MATCH  = 0;
	localparam int ST_UPDATE = 1;
	localparam int ST_W      = 2;

	localparam logic [DATA_W-1:0] RST_MODE   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_VALUE  = 32'h0000_0000;
	localparam logic [ST_W-1:0]   RST_STATUS = 2'h0;
	localparam logic [ST_W-1:0]   RST_MASK   = 2'h0;
	localparam logic [CNT_W-1:0]  CNT_ZERO   = 4'h0;
	localparam logic [CNT_W-1:0]  CNT_ONE    = 4'h1;

endpackage

//--- core/pwmcmp_wrap_counter.sv
/*
	pwmcmp_wrap_counter: counter that steps on each advance pulse and wraps to zero past its limit.
	assumes: advance is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module pwmcmp_wrap_counter
	import pwmcmp_pkg::*;
#(
	parameter int W = CNT_W
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         reset_n,
	// control
	input  wire logic         advance,
	input  wire logic [W-1:0] limit,
	// state
	output logic      [W-1:0] count,
	output logic              wrap
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	wire          at_limit = (count_reg >= limit);

	assign wrap       = advance && at_limit;
	assign count_next = wrap ? '0 : (advance ? count_reg + W'(1) : count_reg);
	assign count      = count_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

endmodule

//--- core/pwmcmp_unit.sv
/*
	pwmcmp_unit: periodic comparison unit x of a pwm controller, with register port and interrupt.
	assumes: period_end is a one-cycle pulse from channel 0 counter logic on the same clock;
	counter_value is the channel 0 counter, also on this clock.
*/
`timescale 1ns/1ps
// Summary of operation
// - enable bit low: comparison never matches; high: comparison may match.
// - compare only in the period where period counter equals trigger value.
// - period field is the largest value the period counter reaches before restarting.
// - comparison is evaluated once every period field plus one channel 0 periods.
// - period counter readable in mode register; writes to it are ignored.
// - new mode and value take effect once every update period plus one periods.
// - update counter readable in mode register; writes to it are ignored.
module pwmcmp_unit
	import pwmcmp_pkg::*;
#(
	parameter int CW = 16
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              reset_n,
	// register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [DATA_W-1:0] rd_data,
	// channel 0 counter
	input  wire logic              period_end,
	input  wire logic [CW-1:0]     counter_value,
	// outputs
	output logic                   match,
	output logic                   irq
);

	// software-side (pending) and active copies
	logic [DATA_W-1:0] mode_sw_reg;
	logic [DATA_W-1:0] value_sw_reg;
	logic [DATA_W-1:0] mode_act_reg;
	logic [DATA_W-1:0] value_act_reg;
	logic [ST_W-1:0]   status_reg;
	logic [ST_W-1:0]   status_next;
	logic [ST_W-1:0]   mask_reg;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;
	logic              match_reg;
	logic              match_next;

	// decode
	wire sel_mode   = (addr == OFS_MODE);
	wire sel_value  = (addr == OFS_VALUE);
	wire sel_status = (addr == OFS_STATUS);
	wire sel_mask   = (addr == OFS_MASK);
	wire wr_mode    = wr_en && sel_mode;
	wire wr_value   = wr_en && sel_value;
	wire wr_status  = wr_en && sel_status;
	wire wr_mask    = wr_en && sel_mask;

	// active fields; update period from the software copy
	wire             act_enable = mode_act_reg[FLD_ENABLE];
	wire [CNT_W-1:0] act_trig   = mode_act_reg[FLD_TRIG_LSB +: CNT_W];
	wire [CNT_W-1:0] act_per    = mode_act_reg[FLD_PER_LSB +: CNT_W];
	wire [CNT_W-1:0] sw_uper    = mode_sw_reg[FLD_UPER_LSB +: CNT_W];
	wire [CW-1:0]    act_value  = value_act_reg[CW-1:0];

	// period and update counters
	wire [CNT_W-1:0] per_count;
	wire [CNT_W-1:0] upd_count;
	wire             per_wrap;
	wire             upd_wrap;

	pwmcmp_wrap_counter #(
		.W(CNT_W)
	) u_period_cnt (
		.clock   (clock),
		.reset_n (reset_n),
		.advance (period_end),
		.limit   (act_per),
		.count   (per_count),
		.wrap    (per_wrap)
	);

	pwmcmp_wrap_counter #(
		.W(CNT_W)
	) u_update_cnt (
		.clock   (clock),
		.reset_n (reset_n),
		.advance (period_end),
		.limit   (sw_uper),
		.count   (upd_count),
		.wrap    (upd_wrap)
	);

	// update happens when the update counter wraps
	wire do_update = upd_wrap;

	// comparison
	wire in_window  = (per_count == act_trig);
	wire value_hit  = (counter_value == act_value);
	assign match_next = act_enable && in_window && value_hit;

	// read mux: counter fields reflect hardware state
	wire [DATA_W-1:0] mode_view = {8'h00,
		upd_count, sw_uper,
		per_count, mode_sw_reg[FLD_PER_LSB +: CNT_W],
		mode_sw_reg[FLD_TRIG_LSB +: CNT_W],
		3'h0, mode_sw_reg[FLD_ENABLE]};

	assign rd_data_next = !rd_en     ? rd_data_reg :
	                      sel_mode   ? mode_view :
	                      sel_value  ? value_sw_reg :
	                      sel_status ? {{(DATA_W-ST_W){1'b0}}, status_reg} :
	                      sel_mask   ? {{(DATA_W-ST_W){1'b0}}, mask_reg} :
	                      {DATA_W{1'b0}};

	// sticky events, set wins over write-one-to-clear
	wire            match_rise = match_next && !match_reg;
	wire [ST_W-1:0] ev_set     = {do_update, match_rise};
	wire [ST_W-1:0] ev_clr = wr_status ? wr_data[ST_W-1:0] : {ST_W{1'b0}};
	assign status_next = (status_reg & ~ev_clr) | ev_set;

	// writable bits: counter fields held at zero in the software copy
	wire [DATA_W-1:0] mode_wmask = {8'h00, 4'h0, 4'hF, 4'h0, 4'hF, 4'hF, 4'h1};

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode_sw_reg <= RST_MODE;
			value_sw_reg <= RST_VALUE;
		end else begin
			if (wr_mode) begin
				mode_sw_reg <= wr_data & mode_wmask;
			end
			if (wr_value) begin
				value_sw_reg <= wr_data;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode_act_reg <= RST_MODE;
			value_act_reg <= RST_VALUE;
		end else if (do_update) begin
			mode_act_reg <= mode_sw_reg;
			value_act_reg <= value_sw_reg;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			status_reg <= RST_STATUS;
			mask_reg <= RST_MASK;
			rd_data_reg <= '0;
			match_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			if (wr_mask) begin
				mask_reg <= wr_data[ST_W-1:0];
			end
			rd_data_reg <= rd_data_next;
			match_reg <= match_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign match   = match_reg;
	assign irq     = |(status_reg & mask_reg);

endmodule

//--- tb/pwmcmp_props.sv
/* pwmcmp_props: port assertions of the periodic comparison unit.
	assumes: bound to pwmcmp_unit, strobes low during reset. */
`timescale 1ns/1ps
module pwmcmp_props
	import pwmcmp_pkg::*;
#(
	parameter int CW = 16
) (
	// clock and reset
	input wire logic              clock,
	input wire logic              reset_n,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic              wr_en,
	input wire logic              rd_en,
	input wire logic [DATA_W-1:0] rd_data,
	// channel 0 counter
	input wire logic              period_end,
	input wire logic [CW-1:0]     counter_value,
	// outputs
	input wire logic              match,
	input wire logic              irq
);
	logic pe_seen_reg;
	wire  mode_rd = rd_en && addr == OFS_MODE;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) pe_seen_reg <= 1'b0;
		else if (period_end) pe_seen_reg <= 1'b1;
	end
	a_match_after_load: assert property (match |-> pe_seen_reg)
		else $error("match before first period end");
	a_irq_after_event: assert property (irq |-> pe_seen_reg)
		else $error("irq before first period end");
	a_count_hold: assert property (mode_rd && !period_end ##1 mode_rd |=> $stable(rd_data))
		else $error("mode changed without period end");
	a_pcnt_step: assert property (mode_rd && period_end ##1 mode_rd |=>
		rd_data[15:12] == $past(rd_data[15:12]) + 4'h1 || rd_data[15:12] == 4'h0)
		else $error("period counter step wrong");
	a_ucnt_step: assert property (mode_rd && period_end ##1 mode_rd |=>
		rd_data[23:20] == $past(rd_data[23:20]) + 4'h1 || rd_data[23:20] == 4'h0)
		else $error("update counter step wrong");
	a_ro_write: assert property (mode_rd && !period_end ##1 wr_en && addr == OFS_MODE && !period_end
		##1 mode_rd |=> rd_data[23:20] == $past(rd_data[23:20], 2) && rd_data[15:12] == $past(rd_data[15:12], 2))
		else $error("counter field took a write");
	a_rsvd_zero: assert property ($past(mode_rd) |-> rd_data[31:24] == 8'h00 && rd_data[3:1] == 3'h0)
		else $error("reserved mode bits set");
	a_rd_hold: assert property (!$past(rd_en) |-> $stable(rd_data))
		else $error("read data moved without read");
endmodule

bind pwmcmp_unit pwmcmp_props #(.CW(CW)) u_props (.*);

//--- tb/pwmcmp_unit_tb.sv
/* pwmcmp_unit_tb: random self-checking bench of the comparison unit.
	assumes: package, design and checker compiled first. */
`timescale 1ns/1ps
module pwmcmp_unit_tb
	import pwmcmp_pkg::*;
;
	`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t %h %h", $time, g, e); end end
	logic              clock, reset_n, wr_en, rd_en, period_end, match, irq, en, act;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic [15:0]       counter_value, v;
	logic [3:0]        p, u, t, uc, pc;
	int                n_errors, samples_checked;
	pwmcmp_unit u_dut (.*);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] mode_exp();
		return {8'h00, uc, u, pc, p, t, 3'h0, en};
	endfunction
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic pe);
		addr <= a;
		rd_en <= 1'b1;
		wr_en <= 1'b0;
		period_end <= pe;
		@(posedge clock);
		#1;
		`CHK(rd_data, e)
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		period_end <= 1'b0;
		@(posedge clock);
		#1;
	endtask
	task automatic step();
		rd(OFS_MODE, mode_exp(), 1'b1);
		pc = (act && pc < p) ? pc + 4'h1 : 4'h0;
		if (uc >= u) act = 1'b1;
		uc = (uc >= u) ? 4'h0 : uc + 4'h1;
		counter_value <= v;
		rd(OFS_MODE, mode_exp(), 1'b0);
		`CHK(match, en && act && pc == t)
		counter_value <= ~v;
		rd(OFS_MODE, mode_exp(), 1'b0);
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		{reset_n, wr_en, rd_en, period_end, addr, wr_data, counter_value} = '0;
		void'($urandom(99142));
		for (int pass = 0; pass < 2; pass++) begin
			{reset_n, wr_en, rd_en, period_end} <= 4'h0;
			repeat (4) @(posedge clock);
			reset_n <= 1'b1;
			#1;
			en = pass[0];
			u = 4'($urandom % 4);
			p = 4'($urandom % 4);
			t = 4'($urandom % (p + 1));
			v = 16'($urandom);
			{uc, pc, act} = '0;
			for (int a = 0; a < 16; a += 2) rd(4'(a), 32'h0000_0000, 1'b0);
			wr(OFS_VALUE, {~v, v});
			wr(OFS_MASK, 32'h0000_0003);
			wr(OFS_MODE, {8'($urandom), 4'hf, u, 4'hf, p, t, 3'h7, en});
			rd(OFS_MODE, mode_exp(), 1'b0);
			`CHK(irq, 1'b0)
			repeat (24) step();
			rd(OFS_MODE, mode_exp(), 1'b0);
			wr(OFS_MODE, {8'hff, 4'hf, u, 4'hf, p, t, 3'h7, en});
			rd(OFS_MODE, mode_exp(), 1'b0);
			rd(OFS_STATUS, {30'h0, 1'b1, en}, 1'b0);
			`CHK(irq, 1'b1)
			wr(OFS_MASK, 32'h0000_0000);
			`CHK(irq, 1'b0)
			wr(OFS_MASK, 32'h0000_0002);
			`CHK(irq, 1'b1)
			wr(OFS_STATUS, 32'h0000_0003);
			`CHK(irq, 1'b0)
			rd(OFS_STATUS, 32'h0000_0000, 1'b0);
		end
		report_and_stop();
	end
endmodule
